// file: hw/ctx_chan_map.vh
// Register offsets, field positions and timing counts for the channel block
`ifndef CTX_CHAN_MAP_VH
`define CTX_CHAN_MAP_VH

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define CTX_OFS_RX_PTR 8'h0c
`define CTX_OFS_RX_LEVEL 8'h0c
`define CTX_OFS_FIFO 8'h10
`define CTX_OFS_TX_AE_LVL 8'h14
`define CTX_OFS_RX_AF_LVL 8'h18
`define CTX_OFS_TX_CTRL 8'h1c
`define CTX_OFS_TX_WORDS 8'h20
`define CTX_OFS_TX_LOCAL 8'h24
`define CTX_OFS_TX_LOW_TOT 8'h28
`define CTX_OFS_TX_START 8'h2c
`define CTX_OFS_STATUS 8'h30

// ==========================================================================
// Transmitter control fields
// ==========================================================================
`define CTX_CTL_RUN 0
`define CTX_CTL_MOVE 1
`define CTX_CTL_DONE_IRQ 2
`define CTX_CTL_EDGE_IRQ 3
`define CTX_CTL_STARVE_IRQ 4
`define CTX_CTL_SWAP 5
`define CTX_CTL_LEVEL_IRQ 6
`define CTX_CTL_W 7

// ==========================================================================
// Status fields
// ==========================================================================
`define CTX_ST_DONE 0
`define CTX_ST_EDGE 1
`define CTX_ST_STARVE 2
`define CTX_ST_LOW_LEVEL 3
`define CTX_ST_TX_IDLE 4
`define CTX_ST_DMA_BUSY 5
`define CTX_ST_DMA_ERR 6
`define CTX_ST_RX_AF 7
`define CTX_ST_TX_AE 8
`define CTX_ST_DMA_DONE 9
`define CTX_ST_W 10

// ==========================================================================
// Descriptor pointer word fields
// ==========================================================================
`define CTX_PTR_DIR 1
`define CTX_PTR_EOC 0

// ==========================================================================
// Widths, reset values and timing
// ==========================================================================
`define CTX_TX_AE_BITS 12
`define CTX_RX_AF_BITS 13
`define CTX_LVL_BITS 16
`define CTX_RESET_WORD 32'h0000_0000
`define CTX_RESET_CTL 7'h00
`define CTX_PIX_DIV 4'h2

`endif

// file: hw/ctx_chan.v
// Channel transmit path control and receive descriptor DMA registers
`timescale 1ns/1ps
`include "ctx_chan_map.vh"

module ctx_chan (
	input wire core_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata_q,
	output reg reg_rvalid_q,
	output wire mem_req,
	output wire mem_we,
	output reg [31:0] mem_addr_q,
	output reg [31:0] mem_wdata_q,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	input wire [15:0] rx_fifo_level,
	input wire [31:0] rx_fifo_word,
	output wire rx_fifo_pop,
	output reg tx_fifo_push_q,
	output reg [31:0] tx_fifo_data_q,
	input wire [15:0] tx_dma_level,
	input wire [31:0] ext_fifo_level,
	input wire [15:0] sm_fifo_level,
	input wire sm_fifo_empty,
	input wire sm_almost_full,
	input wire [31:0] sm_fifo_word,
	output wire sm_fifo_pop,
	output wire transmit_path_move,
	output reg [15:0] pix_data_q,
	output reg pix_valid_q,
	output wire tx_irq
);

	// ======================================================================
	// States
	// ======================================================================
	localparam [3:0] T_IDLE = 4'b0001;
	localparam [3:0] T_WAIT = 4'b0010;
	localparam [3:0] T_FIRST = 4'b0100;
	localparam [3:0] T_SECOND = 4'b1000;
	localparam [3:0] D_IDLE = 4'b0001;
	localparam [3:0] D_DESC = 4'b0010;
	localparam [3:0] D_POP = 4'b0100;
	localparam [3:0] D_WR = 4'b1000;

	// Word address of a pointer word, low two bits forced clear
	function [31:0] ptr_addr;
		input [31:0] w;
		begin
			ptr_addr = {w[31:2], 2'b00};
		end
	endfunction

	// ======================================================================
	// Registers
	// ======================================================================
	reg [`CTX_CTL_W-1:0] ctl_q;
	reg [`CTX_LVL_BITS-1:0] ae_lvl_q;
	reg [`CTX_LVL_BITS-1:0] af_lvl_q;
	reg [31:0] words_q;
	reg [31:0] low_tot_q;
	reg [31:0] start_q;
	reg done_q;
	reg edge_q;
	reg starve_q;
	reg dma_err_q;
	reg dma_done_q;
	reg was_ae_q;
	reg [15:0] sm_lvl_m_q;
	reg [15:0] sm_lvl_q;
	reg [3:0] tst_q;
	reg [3:0] dst_q;
	reg [3:0] div_q;
	reg [31:0] wcnt_q;
	reg [15:0] hold_q;
	reg [31:0] buf_q;
	reg [31:0] rem_q;
	reg [31:0] next_q;
	reg [31:0] desc_q;
	reg [1:0] idx_q;

	wire wr_fifo = reg_wr && reg_addr == `CTX_OFS_FIFO;
	wire rd_fifo = reg_rd && reg_addr == `CTX_OFS_FIFO;
	wire wr_ptr = reg_wr && reg_addr == `CTX_OFS_RX_PTR;
	wire wr_stat = reg_wr && reg_addr == `CTX_OFS_STATUS;
	wire pix_en = div_q == 4'h0;

	// ======================================================================
	// Level comparisons
	// ======================================================================
	wire [31:0] path_sum = {16'h0000, tx_dma_level} + ext_fifo_level
		+ {16'h0000, sm_lvl_q};
	wire tx_ae = tx_dma_level[`CTX_TX_AE_BITS-1:0]
		< ae_lvl_q[`CTX_TX_AE_BITS-1:0];
	wire tx_ae_at = tx_dma_level[`CTX_TX_AE_BITS-1:0]
		<= ae_lvl_q[`CTX_TX_AE_BITS-1:0];
	wire rx_af = rx_fifo_level[`CTX_RX_AF_BITS-1:0]
		>= af_lvl_q[`CTX_RX_AF_BITS-1:0];
	wire low_level = path_sum < low_tot_q;
	// Start needs the path total and local almost full
	wire start_ok = !(path_sum < start_q) && sm_almost_full;

	assign transmit_path_move = ctl_q[`CTX_CTL_MOVE];
	// Latched status gated by enables; level term is live
	assign tx_irq = (done_q && ctl_q[`CTX_CTL_DONE_IRQ])
		|| (edge_q && ctl_q[`CTX_CTL_EDGE_IRQ])
		|| (starve_q && ctl_q[`CTX_CTL_STARVE_IRQ])
		|| (low_level && ctl_q[`CTX_CTL_LEVEL_IRQ]);

	// ======================================================================
	// Local FIFO level crossing
	// ======================================================================
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sm_lvl_m_q <= 16'h0000;
			sm_lvl_q <= 16'h0000;
		end else begin
			// Binary count, trusted only while static
			sm_lvl_m_q <= sm_fifo_level;
			sm_lvl_q <= sm_lvl_m_q;
		end
	end

	// ======================================================================
	// Register writes
	// ======================================================================
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_q <= `CTX_RESET_CTL;
			ae_lvl_q <= 16'h0000;
			af_lvl_q <= 16'h0000;
			words_q <= `CTX_RESET_WORD;
			low_tot_q <= `CTX_RESET_WORD;
			start_q <= `CTX_RESET_WORD;
			tx_fifo_push_q <= 1'b0;
			tx_fifo_data_q <= `CTX_RESET_WORD;
		end else begin
			// One-cycle push pulse per port write
			tx_fifo_push_q <= wr_fifo;
			if (wr_fifo)
				tx_fifo_data_q <= reg_wdata;
			if (reg_wr) begin
				case (reg_addr)
				`CTX_OFS_TX_AE_LVL: ae_lvl_q <= reg_wdata[15:0];
				`CTX_OFS_RX_AF_LVL: af_lvl_q <= reg_wdata[15:0];
				`CTX_OFS_TX_CTRL: ctl_q <= reg_wdata[`CTX_CTL_W-1:0];
				`CTX_OFS_TX_WORDS: words_q <= reg_wdata;
				`CTX_OFS_TX_LOW_TOT: low_tot_q <= reg_wdata;
				`CTX_OFS_TX_START: start_q <= reg_wdata;
				default: ;
				endcase
			end
		end
	end

	// ======================================================================
	// Register reads
	// ======================================================================
	// Sticky and live bits side by side
	wire [`CTX_ST_W-1:0] status = {dma_done_q, tx_ae, rx_af, dma_err_q,
		dst_q != D_IDLE, tst_q == T_IDLE, low_level, starve_q, edge_q,
		done_q};

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= `CTX_RESET_WORD;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
				`CTX_OFS_RX_LEVEL: reg_rdata_q <= {16'h0000,
					rx_fifo_level};
				`CTX_OFS_FIFO: reg_rdata_q <= rx_fifo_word;
				`CTX_OFS_TX_AE_LVL: reg_rdata_q <= {16'h0000, ae_lvl_q};
				`CTX_OFS_RX_AF_LVL: reg_rdata_q <= {16'h0000, af_lvl_q};
				`CTX_OFS_TX_CTRL: reg_rdata_q <= {25'h0000000, ctl_q};
				`CTX_OFS_TX_WORDS: reg_rdata_q <= words_q;
				`CTX_OFS_TX_LOCAL: reg_rdata_q <= {16'h0000,
					sm_lvl_q};
				`CTX_OFS_TX_LOW_TOT: reg_rdata_q <= low_tot_q;
				`CTX_OFS_TX_START: reg_rdata_q <= start_q;
				`CTX_OFS_STATUS: reg_rdata_q <= {22'h000000, status};
				default: reg_rdata_q <= `CTX_RESET_WORD;
				endcase
			end
		end
	end

	// ======================================================================
	// Pixel transmitter
	// ======================================================================
	// One word feeds a pixel pair
	wire need_word = tst_q == T_FIRST && pix_en && ctl_q[`CTX_CTL_RUN];
	wire starve_ev = need_word && sm_fifo_empty;
	wire done_ev = tst_q == T_SECOND && pix_en && ctl_q[`CTX_CTL_RUN]
		&& wcnt_q + 32'h1 >= words_q;
	assign sm_fifo_pop = need_word && !sm_fifo_empty;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tst_q <= T_IDLE;
			div_q <= 4'h0;
			wcnt_q <= `CTX_RESET_WORD;
			hold_q <= 16'h0000;
			pix_data_q <= 16'h0000;
			pix_valid_q <= 1'b0;
		end else begin
			pix_valid_q <= 1'b0;
			// Free-running pixel pace divider
			div_q <= pix_en ? `CTX_PIX_DIV - 4'h1 : div_q - 4'h1;
			if (!ctl_q[`CTX_CTL_RUN]) begin
				tst_q <= T_IDLE;
				wcnt_q <= `CTX_RESET_WORD;
			end else begin
				case (tst_q)
				T_IDLE: tst_q <= T_WAIT;
				T_WAIT: if (start_ok) tst_q <= T_FIRST;
				T_FIRST: if (sm_fifo_pop) begin
					pix_valid_q <= 1'b1;
					if (ctl_q[`CTX_CTL_SWAP]) begin
						pix_data_q <= sm_fifo_word[31:16];
						hold_q <= sm_fifo_word[15:0];
					end else begin
						pix_data_q <= sm_fifo_word[15:0];
						hold_q <= sm_fifo_word[31:16];
					end
					tst_q <= T_SECOND;
				end
				T_SECOND: if (pix_en) begin
					pix_valid_q <= 1'b1;
					pix_data_q <= hold_q;
					wcnt_q <= done_ev ? `CTX_RESET_WORD : wcnt_q + 32'h1;
					tst_q <= T_FIRST;
				end
				default: tst_q <= T_IDLE;
				endcase
			end
		end
	end

	// ======================================================================
	// Sticky status, set wins over clear
	// ======================================================================
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
			edge_q <= 1'b0;
			starve_q <= 1'b0;
			// Starts high so reset makes no false edge
			was_ae_q <= 1'b1;
		end else begin
			was_ae_q <= tx_ae_at;
			done_q <= done_ev
				|| (done_q && !(wr_stat && reg_wdata[`CTX_ST_DONE]));
			edge_q <= (tx_ae_at && !was_ae_q)
				|| (edge_q && !(wr_stat && reg_wdata[`CTX_ST_EDGE]));
			starve_q <= starve_ev
				|| (starve_q && !(wr_stat && reg_wdata[`CTX_ST_STARVE]));
		end
	end

	// ======================================================================
	// Receive descriptor DMA
	// ======================================================================
	// Host read of the port wins the head word
	wire dma_pop = dst_q == D_POP && rem_q != 32'h0
		&& rx_fifo_level != 16'h0000 && !rd_fifo;
	assign rx_fifo_pop = rd_fifo || dma_pop;
	assign mem_req = dst_q == D_DESC || dst_q == D_WR;
	assign mem_we = dst_q == D_WR;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dst_q <= D_IDLE;
			idx_q <= 2'b00;
			buf_q <= `CTX_RESET_WORD;
			rem_q <= `CTX_RESET_WORD;
			next_q <= `CTX_RESET_WORD;
			desc_q <= `CTX_RESET_WORD;
			mem_addr_q <= `CTX_RESET_WORD;
			mem_wdata_q <= `CTX_RESET_WORD;
			dma_err_q <= 1'b0;
			dma_done_q <= 1'b0;
		end else begin
			if (wr_stat && reg_wdata[`CTX_ST_DMA_ERR])
				dma_err_q <= 1'b0;
			if (wr_stat && reg_wdata[`CTX_ST_DMA_DONE])
				dma_done_q <= 1'b0;
			// Zero aborts; any other pointer restarts the chain
			if (wr_ptr && reg_wdata == 32'h0) begin
				dst_q <= D_IDLE;
			end else if (wr_ptr) begin
				desc_q <= ptr_addr(reg_wdata);
				mem_addr_q <= ptr_addr(reg_wdata);
				idx_q <= 2'b00;
				dst_q <= D_DESC;
			end else begin
				case (dst_q)
				D_IDLE: ;
				D_DESC: if (mem_ack) begin
					idx_q <= idx_q + 2'b01;
					mem_addr_q <= mem_addr_q + 32'h4;
					if (idx_q == 2'b00)
						buf_q <= ptr_addr(mem_rdata);
					if (idx_q == 2'b01)
						rem_q <= {2'b00, mem_rdata[31:2]};
					// Third word: next pointer with its flag bits
					if (idx_q == 2'b10) begin
						next_q <= mem_rdata;
						mem_addr_q <= buf_q;
						if (!mem_rdata[`CTX_PTR_DIR]) begin
							dma_err_q <= 1'b1;
							dst_q <= D_IDLE;
						end else
							dst_q <= D_POP;
					end
				end
				// One pop, then one host write, per word
				D_POP: if (rem_q == 32'h0) begin
					if (next_q[`CTX_PTR_EOC]) begin
						dma_done_q <= 1'b1;
						dst_q <= D_IDLE;
					end else begin
						desc_q <= ptr_addr(next_q);
						mem_addr_q <= ptr_addr(next_q);
						idx_q <= 2'b00;
						dst_q <= D_DESC;
					end
				end else if (dma_pop) begin
					mem_wdata_q <= rx_fifo_word;
					dst_q <= D_WR;
				end
				D_WR: if (mem_ack) begin
					mem_addr_q <= mem_addr_q + 32'h4;
					rem_q <= rem_q - 32'h1;
					dst_q <= D_POP;
				end
				default: dst_q <= D_IDLE;
				endcase
			end
		end
	end

endmodule // ctx_chan

// file: test/ctx_chan_assertions.sv
// Port-level checks for the channel block
`timescale 1ns/1ps
module ctx_chan_chk (
	input wire core_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata_q,
	input wire reg_rvalid_q,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr_q,
	input wire mem_ack,
	input wire [31:0] rx_fifo_word,
	input wire rx_fifo_pop,
	input wire tx_fifo_push_q,
	input wire [31:0] tx_fifo_data_q,
	input wire [31:0] sm_fifo_word,
	input wire sm_fifo_pop,
	input wire transmit_path_move,
	input wire [15:0] pix_data_q,
	input wire pix_valid_q,
	input wire tx_irq
);
	// ==========================================================
	// Shadow of the control register
	// ==========================================================
	reg [6:0] ctl_q;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			ctl_q <= 7'h00;
		else if (reg_wr && reg_addr == 8'h1c)
			ctl_q <= reg_wdata[6:0];
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Properties
	// ==========================================================
	sequence s_mem_wait;
		mem_req && !mem_ack && !(reg_wr && reg_addr == 8'h0c);
	endsequence
	sequence s_port_read;
		reg_rd && reg_addr == 8'h10 ##0 rx_fifo_pop;
	endsequence
	property p_pop;
		reg_rd && reg_addr == 8'h10 |-> s_port_read ##1
			(reg_rvalid_q && reg_rdata_q == $past(rx_fifo_word));
	endproperty
	a_pop: assert property (p_pop) else $error("port read wrong");
	property p_push;
		reg_wr && reg_addr == 8'h10 |=> tx_fifo_push_q &&
			tx_fifo_data_q == $past(reg_wdata);
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_start;
		reg_wr && reg_addr == 8'h0c && reg_wdata != 0 && !mem_req |=>
			mem_req && !mem_we && mem_addr_q[31:2] == $past(reg_wdata[31:2]);
	endproperty
	a_start: assert property (p_start) else $error("dma start");
	property p_abort;
		reg_wr && reg_addr == 8'h0c && reg_wdata == 0 |=> !mem_req [*2];
	endproperty
	a_abort: assert property (p_abort) else $error("abort failed");
	property p_hold;
		s_mem_wait |=> mem_req && $stable(mem_addr_q) && $stable(mem_we);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_move;
		reg_wr && reg_addr == 8'h1c |=> transmit_path_move == $past(reg_wdata[1]);
	endproperty
	a_move: assert property (p_move) else $error("path move");
	property p_irq_mask;
		ctl_q[2] == 0 && ctl_q[3] == 0 && ctl_q[4] == 0 && ctl_q[6] == 0
			|-> !tx_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq");
	property p_pixel;
		sm_fifo_pop |=> pix_valid_q && pix_data_q == ($past(ctl_q[5]) ?
			$past(sm_fifo_word[31:16]) : $past(sm_fifo_word[15:0]));
	endproperty
	a_pixel: assert property (p_pixel) else $error("first pixel");
endmodule // ctx_chan_chk

bind ctx_chan ctx_chan_chk chk (.core_clk, .resetn, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .mem_req, .mem_we,
	.mem_addr_q, .mem_ack, .rx_fifo_word, .rx_fifo_pop, .tx_fifo_push_q,
	.tx_fifo_data_q, .sm_fifo_word, .sm_fifo_pop, .transmit_path_move,
	.pix_data_q, .pix_valid_q, .tx_irq);

// file: test/ctx_host_mem.sv
// Host memory model answering the channel DMA requests
`timescale 1ns/1ps
module ctx_host_mem (
	input wire core_clk,
	input wire resetn,
	input wire slow,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr_q,
	input wire [31:0] mem_wdata_q,
	output reg mem_ack,
	output wire [31:0] mem_rdata
);
	reg [31:0] ram [0:255];
	reg [1:0] wait_q;
	integer i;
	wire [7:0] idx = mem_addr_q[9:2];
	// Outside the answer cycle the data lines show the inverse
	assign mem_rdata = mem_ack ? ram[idx] : ~ram[idx];
	initial for (i = 0; i < 256; i = i + 1) ram[i] = 32'h0;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			wait_q <= 2'd0;
		end else begin
			mem_ack <= 1'b0;
			if (mem_ack && mem_req && mem_we)
				ram[idx] <= mem_wdata_q;
			if (mem_req && !mem_ack) begin
				wait_q <= wait_q + 2'd1;
				if (wait_q == (slow ? 2'd3 : 2'd0)) begin
					mem_ack <= 1'b1;
					wait_q <= 2'd0;
				end
			end
		end
	end
endmodule // ctx_host_mem

// file: test/testbench.sv
// Self-checking bench for the channel block
`timescale 1ns/1ps
`define CHK(a, b) begin \
	checks = checks + 1; \
	if ((a) !== (b)) begin \
		fail_count = fail_count + 1; \
		$display("mismatch %0t value differs", $time); \
	end \
end
module testbench;
	reg core_clk = 1'b0;
	reg resetn = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [31:0] reg_wdata = 32'h0;
	reg slow = 1'b0;
	reg sm_almost_full = 1'b0;
	reg [15:0] tx_dma_level = 16'h0;
	reg [31:0] ext_fifo_level = 32'h0;
	reg [15:0] rx_in = 16'h0, rx_out = 16'h0, sm_wr = 16'h0, sm_rd = 16'h0;
	reg [15:0] r0, w;
	reg [31:0] seed = 32'hab6785d3;
	reg [31:0] eq [$];
	reg [31:0] mq [$];
	reg [15:0] pq [$];
	reg [7:0] ofs [0:5] = '{8'h14, 8'h18, 8'h20, 8'h28, 8'h2c, 8'h1c};
	reg [31:0] msk [0:5] = '{32'hffff, 32'hffff, 32'hffffffff,
		32'hffffffff, 32'hffffffff, 32'h7f};
	integer fail_count = 0, checks = 0, i, k, s;
	wire [31:0] reg_rdata_q, mem_addr_q, mem_wdata_q, mem_rdata, tx_fifo_data_q;
	wire [15:0] pix_data_q;
	wire reg_rvalid_q, mem_req, mem_we, mem_ack, rx_fifo_pop, tx_fifo_push_q;
	wire sm_fifo_pop, transmit_path_move, pix_valid_q, tx_irq;
	ctx_chan dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.rx_fifo_level(rx_in - rx_out), .rx_fifo_word({16'h1000, rx_out}),
		.rx_fifo_pop(rx_fifo_pop), .tx_fifo_push_q(tx_fifo_push_q),
		.tx_fifo_data_q(tx_fifo_data_q), .tx_dma_level(tx_dma_level),
		.ext_fifo_level(ext_fifo_level), .sm_fifo_level(sm_wr - sm_rd),
		.sm_fifo_empty(sm_wr == sm_rd), .sm_almost_full(sm_almost_full),
		.sm_fifo_word({16'ha000 + sm_rd, 16'h5000 + sm_rd}),
		.sm_fifo_pop(sm_fifo_pop), .transmit_path_move(transmit_path_move),
		.pix_data_q(pix_data_q), .pix_valid_q(pix_valid_q), .tx_irq(tx_irq));
	ctx_host_mem mem (.core_clk(core_clk), .resetn(resetn), .slow(slow),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ==========================================================
	// Helpers
	// ==========================================================
	function [31:0] xs(input [31:0] v);
		reg [31:0] x;
		begin
			x = v ^ (v << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task wr(input [7:0] a, input [31:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
	endtask
	task final_report;
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Clock, FIFO models, watchers
	// ==========================================================
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (rx_fifo_pop === 1'b1)
			rx_out <= rx_out + 16'd1;
		if (sm_fifo_pop === 1'b1)
			sm_rd <= sm_rd + 16'd1;
	end
	always @(negedge core_clk) begin
		if (reg_rvalid_q === 1'b1) begin
			`CHK(eq.size() > 0, 1'b1)
			`CHK(reg_rdata_q & mq.pop_front(), eq.pop_front())
		end
		if (pix_valid_q === 1'b1) begin
			`CHK(pq.size() > 0, 1'b1)
			if (pq.size() > 0)
				`CHK(pix_data_q, pq.pop_front())
		end
	end
	initial begin
		#(50 * 20000);
		fail_count = fail_count + 1;
		final_report;
	end
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (10) @(negedge core_clk);
		resetn = 1'b1;
		rd(8'h1c, 32'h0, 32'hffffffff);
		rd(8'h50, 32'h0, 32'hffffffff);
		for (i = 0; i < 6; i = i + 1) begin
			seed = xs(seed);
			wr(ofs[i], seed);
			rd(ofs[i], seed, msk[i]);
			rd(ofs[i], 32'h0, ~msk[i]);
		end
		wr(8'h1c, 32'h0);
		sm_wr = 16'd5;
		rx_in = 16'h1003;
		wr(8'h10, seed);
		rd(8'h0c, 32'h1003, 32'hffffffff);
		rd(8'h24, 32'h5, 32'hffffffff);
		rd(8'h10, 32'h10000000, 32'hffffffff);
		rx_in = 16'd4;
		slow = 1'b1;
		// Direction set everywhere, end bit only in the last next word
		mem.ram[16] = 32'h80;
		mem.ram[17] = 32'd8;
		mem.ram[18] = 32'h52;
		mem.ram[20] = 32'h90;
		mem.ram[21] = 32'd4;
		mem.ram[22] = 32'h3;
		r0 = 16'd1;
		wr(8'h0c, 32'h40);
		for (k = 0; k < 300 && mem.ram[36] === 32'h0; k = k + 1)
			@(negedge core_clk);
		repeat (20) @(negedge core_clk);
		`CHK(mem.ram[32], {16'h1000, r0})
		`CHK(mem.ram[33], {16'h1000, r0 + 16'd1})
		`CHK(mem.ram[36], {16'h1000, r0 + 16'd2})
		`CHK(mem.ram[37], 32'h0)
		mem.ram[24] = 32'ha0;
		mem.ram[25] = 32'd64;
		mem.ram[26] = 32'h3;
		wr(8'h0c, 32'h60);
		repeat (20) @(negedge core_clk);
		wr(8'h0c, 32'h0);
		rx_in = rx_out + 16'd2;
		repeat (20) @(negedge core_clk);
		`CHK(mem.ram[40], 32'h0)
		rd(8'h0c, 32'h2, 32'hffffffff);
		wr(8'h14, 32'd5);
		tx_dma_level = 16'd6;
		wr(8'h30, 32'h2);
		rd(8'h30, 32'h0, 32'h102);
		tx_dma_level = 16'd5;
		repeat (2) @(negedge core_clk);
		rd(8'h30, 32'h2, 32'h102);
		tx_dma_level = 16'd3;
		ext_fifo_level = 32'd4;
		wr(8'h28, 32'd13);
		wr(8'h1c, 32'h40);
		repeat (4) @(negedge core_clk);
		`CHK(tx_irq, 1'b1)
		wr(8'h28, 32'd12);
		`CHK(tx_irq, 1'b0)
		wr(8'h20, 32'd2);
		for (s = 0; s < 2; s = s + 1) begin
			// First pass lacks almost full, second lacks the path total
			sm_almost_full = (s == 1);
			sm_wr = sm_rd + 16'd2;
			wr(8'h2c, s ? 32'd10 : 32'd9);
			wr(8'h1c, s ? 32'h25 : 32'h05);
			// Any pixel here finds the queue empty
			repeat (20) @(negedge core_clk);
			for (k = 0; k < 2; k = k + 1) begin
				w = sm_rd + k;
				pq.push_back(s ? 16'ha000 + w : 16'h5000 + w);
				pq.push_back(s ? 16'h5000 + w : 16'ha000 + w);
			end
			wr(8'h2c, 32'd9);
			sm_almost_full = 1'b1;
			for (k = 0; k < 200 && pq.size() > 0; k = k + 1)
				@(negedge core_clk);
			repeat (8) @(negedge core_clk);
			`CHK(tx_irq, 1'b1)
			rd(8'h30, 32'h5, 32'h5);
			wr(8'h30, 32'h247);
			`CHK(tx_irq, 1'b0)
			wr(8'h1c, 32'h0);
		end
		`CHK(pq.size(), 0)
		final_report;
	end
endmodule // testbench
